/* verilog/pvcfg_params.svh */
`ifndef PVCFG_PARAMS_SVH
`define PVCFG_PARAMS_SVH

// locator capability layout
`define PVCFG_CAP_ID_VENDOR   8'h09
`define PVCFG_CAP_LENGTH      8'h0C
`define PVCFG_CAP_OFS_WORD0   4'h0
`define PVCFG_CAP_OFS_WORD1   4'h4
`define PVCFG_CAP_OFS_WORD2   4'h8
`define PVCFG_CAP_OFS_STRUCT  4'h3
`define PVCFG_BAR_CFG_BASE    8'h10
`define PVCFG_BIR_MAX         3'h5

// structure identifiers
`define PVCFG_SID_HEADER      8'h01
`define PVCFG_SID_NOTIFY      8'h02
`define PVCFG_SID_ISR         8'h03
`define PVCFG_SID_DEVHDR      8'h04

// structure alignments and minimum sizes in bytes
`define PVCFG_HDR_ALIGN       32'h0000_0004
`define PVCFG_HDR_MIN_SIZE    32'h0000_001C
`define PVCFG_NOTIFY_SIZE     32'h0000_0002
`define PVCFG_ISR_SIZE        32'h0000_0001

// header field byte offsets
`define PVCFG_HDR_DFEAT_LO    8'h00
`define PVCFG_HDR_GFEAT_LO    8'h04
`define PVCFG_HDR_QADDR       8'h08
`define PVCFG_HDR_QSIZE       8'h0C
`define PVCFG_HDR_QSEL        8'h0E
`define PVCFG_HDR_RSVD16      8'h10
`define PVCFG_HDR_STATUS      8'h12
`define PVCFG_HDR_RSVD8       8'h13
`define PVCFG_HDR_CFGVEC      8'h14
`define PVCFG_HDR_QVEC        8'h16
`define PVCFG_HDR_DFEAT_HI    8'h18
`define PVCFG_HDR_GFEAT_HI    8'h1C

// legacy BAR0 mirror byte offsets
`define PVCFG_LEG_NOTIFY      8'h10
`define PVCFG_LEG_ISR         8'h13
`define PVCFG_LEG_DEV_MSIX    8'h18
`define PVCFG_LEG_DEV_NOMSIX  8'h14

// device status values and reset values
`define PVCFG_ST_FOUND        8'h01
`define PVCFG_ST_DRIVER       8'h02
`define PVCFG_ST_READY        8'h04
`define PVCFG_ST_GAVE_UP      8'h80
`define PVCFG_NO_VECTOR       16'hFFFF
`define PVCFG_FEAT_HI_GATE    5'd31

`endif

/* verilog/pvcfg_pkg.sv */
package pvcfg_pkg;

  // one register access from the configuration or BAR decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pvcfg_req_t;

  // which address space an access targets
  typedef enum logic [1:0] {
    PVCFG_SPACE_CAP    = 2'b00,
    PVCFG_SPACE_HEADER = 2'b01,
    PVCFG_SPACE_LEGACY = 2'b10,
    PVCFG_SPACE_NONE   = 2'b11
  } pvcfg_space_t;

  // one locator capability description
  typedef struct packed {
    logic [7:0]  sid;
    logic [7:0]  next_ptr;
    logic [2:0]  bar_indicator;
    logic [31:0] size;
    logic [31:0] offset;
  } pvcfg_loc_t;

endpackage

/* verilog/pvcfg_regs.sv */
// Summary of operation
// RULE1 - every locator entry carries capability identifier 9
// RULE2 - every locator entry reports capability length 12
// RULE3 - word0 holds id, next pointer, length, structure id; size at 4, offset 8
// RULE4 - locator fields little endian and read only; writes ignored
// RULE5 - bar indicator only 0 to 5, BAR at 10h plus four times it
// RULE6 - selected BAR may be 32 or 64 bit, memory or I/O
// RULE7 - host adds offset to BAR base, masking low bits for alignment
// RULE8 - host ignores unknown structure identifiers
// RULE9 - structure ids: 1 header, 2 notify, 3 ISR status, 4 device header
// RULE10 - header 4-aligned at least 28 bytes; notify 2 bytes; ISR 1 byte
// RULE11 - legacy: header 0, notify 16, ISR 19, device header 24 or 20
// RULE12 - host uses legacy copy when a locator is missing
// RULE13 - legacy I/O mirror of the initial portion is provided
// RULE14 - legacy header 20 bytes, 24 with MSI-X; locator structures never move
// RULE15 - host avoids legacy copy when a locator exists
// RULE16 - header field order and widths with their access types
// RULE17 - size may include padding; host maps only what it needs
// RULE18 - one locator per structure, chained in the capability list
// RULE19 - host validates bar indicator, offset and size
// RULE20 - host must not assume structure sizes are fixed
// RULE21 - notify and ISR structures are single register fields
// RULE22 - writing zero to device status resets the device
// RULE23 - status bits: 1 found, 2 driver, 4 ready, 128 gave up
// RULE24 - features above 31 treated clear unless accepted bit 31 set
// RULE25 - reserved fields read zero; writes to reserved or read-only ignored
// RULE26 - fields answer natural-width accesses at their packed offsets
`timescale 1ns/10ps
`default_nettype none
`include "pvcfg_params.svh"

module pvcfg_regs
  import pvcfg_pkg::*;
#(
  parameter int          NUM_LOC     = 4,
  parameter logic [7:0]  CAP_BASE    = 8'h40,
  parameter logic [2:0]  HDR_BAR     = 3'h1,
  parameter logic [31:0] HDR_OFFSET  = 32'h0000_1000,
  parameter logic [31:0] HDR_SIZE    = 32'h0000_0100,
  parameter logic [31:0] NTF_OFFSET  = 32'h0000_1200,
  parameter logic [31:0] ISR_OFFSET  = 32'h0000_1300,
  parameter logic [31:0] DEV_OFFSET  = 32'h0000_1400,
  parameter logic [31:0] DEV_SIZE    = 32'h0000_0020,
  parameter logic [31:0] OFFER_LO    = 32'h8000_0000,
  parameter logic [31:0] OFFER_HI    = 32'h0000_0000,
  parameter logic [15:0] RING_COUNT  = 16'h0100,
  parameter int          NUM_RINGS   = 2
) (
  input  wire logic        CLK_I,             // 125 MHz clock
  input  wire logic        RST_N_I,           // async reset, active low
  input  wire pvcfg_req_t  CAP_REQ_I,         // configuration space access
  input  wire pvcfg_req_t  HDR_REQ_I,         // locator BAR access, rel. to header structure
  input  wire pvcfg_req_t  LEG_REQ_I,         // legacy BAR0 access
  input  wire logic        MSIX_EN_I,         // MSI-X enable from config logic
  input  wire logic        ISR_STATUS_I,      // interrupt pending level
  output logic [31:0]      CAP_RDATA_O,       // config read data
  output logic [31:0]      HDR_RDATA_O,       // header BAR read data
  output logic [31:0]      LEG_RDATA_O,       // legacy read data
  output logic [15:0]      NOTIFY_O,          // ring index notified
  output logic             NOTIFY_STB_O,      // notify strobe
  output logic             ISR_READ_O,        // ISR read strobe, clears source
  output logic [7:0]       STATUS_O,          // host progress flags
  output logic [63:0]      FEAT_ACCEPT_O,     // accepted features, gated
  output logic             DEV_RESET_O,       // one-cycle device reset pulse
  output logic [31:0]      RING_PAGE_O,       // page of selected ring
  output logic [15:0]      RING_SEL_O         // selected ring index
);

  // locator table, fixed at build time; all fields read only
  function automatic pvcfg_loc_t loc_entry(input int idx);
    pvcfg_loc_t e;
    e = '0;
    e.bar_indicator = HDR_BAR;                                // RULE5 RULE6
    e.next_ptr = (idx == NUM_LOC - 1) ? 8'h00
               : 8'(CAP_BASE + 8'(12 * (idx + 1)));           // RULE18
    case (idx)
      0: begin
        e.sid = `PVCFG_SID_HEADER;                            // RULE9
        e.size = (HDR_SIZE < `PVCFG_HDR_MIN_SIZE) ? `PVCFG_HDR_MIN_SIZE : HDR_SIZE; // RULE10
        e.offset = HDR_OFFSET & ~(`PVCFG_HDR_ALIGN - 32'h1);  // RULE10
      end
      1: begin
        e.sid = `PVCFG_SID_NOTIFY;
        e.size = `PVCFG_NOTIFY_SIZE;
        e.offset = NTF_OFFSET & 32'hFFFF_FFFE;                // RULE10
      end
      2: begin
        e.sid = `PVCFG_SID_ISR;
        e.size = `PVCFG_ISR_SIZE;
        e.offset = ISR_OFFSET;
      end
      default: begin
        e.sid = `PVCFG_SID_DEVHDR;
        e.size = DEV_SIZE;
        e.offset = DEV_OFFSET;
      end
    endcase
    return e;
  endfunction

  // little-endian read of a locator dword
  function automatic logic [31:0] loc_word(input pvcfg_loc_t e, input logic [3:0] ofs);
    logic [31:0] w;
    w = 32'h0;
    case (ofs)
      `PVCFG_CAP_OFS_WORD0: w = {e.sid, `PVCFG_CAP_LENGTH, e.next_ptr,
                                 `PVCFG_CAP_ID_VENDOR};       // RULE1 RULE2 RULE3
      `PVCFG_CAP_OFS_WORD1: w = {e.size[31:3], e.bar_indicator}; // RULE3
      `PVCFG_CAP_OFS_WORD2: w = e.offset;                     // RULE3
      default:              w = 32'h0;
    endcase
    return w;
  endfunction

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0] accept_lo_reg;
  logic [31:0] accept_hi_reg;
  logic [31:0] ring_page_reg [NUM_RINGS];
  logic [15:0] ring_sel_reg;
  logic [7:0]  status_reg;
  logic [15:0] cfg_vec_reg;
  logic [15:0] ring_vec_reg [NUM_RINGS];
  logic [31:0] cap_rdata_reg;
  logic [31:0] hdr_rdata_reg;
  logic [31:0] leg_rdata_reg;
  logic [15:0] notify_reg;
  logic        notify_stb_reg;
  logic        isr_rd_reg;
  logic        dev_reset_reg;
  logic        msix_meta_reg;
  logic        msix_sync_reg;
  logic        isr_meta_reg;
  logic        isr_sync_reg;
  logic [31:0] ring_page_out_reg;
  logic [63:0] feat_out_reg;

  // header access as one struct, either from the locator BAR or the legacy mirror
  pvcfg_req_t  hdr_rq;
  pvcfg_req_t  leg_hdr_rq;
  logic        sel_valid;
  logic [15:0] sel_idx;
  logic [7:0]  leg_dev_base;

  assign sel_idx   = ring_sel_reg;
  assign sel_valid = (32'(ring_sel_reg) < NUM_RINGS);

  // selected ring fields; an out-of-range select reads as absent
  function automatic logic [31:0] sel_page();
    return sel_valid ? ring_page_reg[sel_idx[0 +: $clog2(NUM_RINGS)]] : 32'h0;
  endfunction

  function automatic logic [15:0] sel_vec();
    return sel_valid ? ring_vec_reg[sel_idx[0 +: $clog2(NUM_RINGS)]] : `PVCFG_NO_VECTOR;
  endfunction

  // legacy device header base moves with MSI-X
  // the vectors sit in front of it only while MSI-X is on
  assign leg_dev_base = msix_sync_reg ? `PVCFG_LEG_DEV_MSIX : `PVCFG_LEG_DEV_NOMSIX; // RULE11 RULE14

  // synchronise level inputs from the PCI config side
  // two stages keep a metastable level off the decoders
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      msix_meta_reg <= 1'b0;
      msix_sync_reg <= 1'b0;
      isr_meta_reg  <= 1'b0;
      isr_sync_reg  <= 1'b0;
    end else begin
      msix_meta_reg <= MSIX_EN_I;
      msix_sync_reg <= msix_meta_reg;
      isr_meta_reg  <= ISR_STATUS_I;
      isr_sync_reg  <= isr_meta_reg;
    end
  end

  // legacy accesses inside the mirrored header are fed to the header path
  always_comb begin
    leg_hdr_rq = LEG_REQ_I;
    if (LEG_REQ_I.addr >= leg_dev_base ||
        LEG_REQ_I.addr == `PVCFG_LEG_NOTIFY || LEG_REQ_I.addr == `PVCFG_LEG_ISR ||
        (!msix_sync_reg && LEG_REQ_I.addr >= `PVCFG_HDR_CFGVEC)) begin // RULE14
      leg_hdr_rq.rd = 1'b0;
      leg_hdr_rq.wr = 1'b0;
    end
    // a header-BAR access wins; a legacy header write in the same cycle is lost
    hdr_rq = HDR_REQ_I.rd | HDR_REQ_I.wr ? HDR_REQ_I : leg_hdr_rq;
  end

  // header read mux; reserved and unmapped read zero
  function automatic logic [31:0] hdr_read(input logic [7:0] a);
    logic [31:0] r;
    logic [31:0] offer_hi;
    r = 32'h0;
    offer_hi = accept_lo_reg[`PVCFG_FEAT_HI_GATE] ? OFFER_HI : 32'h0; // RULE24
    case (a)
      `PVCFG_HDR_DFEAT_LO: r = OFFER_LO;
      `PVCFG_HDR_GFEAT_LO: r = accept_lo_reg;
      `PVCFG_HDR_QADDR:    r = sel_page();
      `PVCFG_HDR_QSIZE:    r = {ring_sel_reg, sel_valid ? RING_COUNT : 16'h0}; // RULE16
      `PVCFG_HDR_QSEL:     r = {16'h0, ring_sel_reg};
      `PVCFG_HDR_RSVD16:   r = {8'h0, status_reg, 16'h0};     // RULE25
      `PVCFG_HDR_STATUS:   r = {24'h0, status_reg};
      `PVCFG_HDR_CFGVEC:   r = {sel_vec(), cfg_vec_reg};
      `PVCFG_HDR_QVEC:     r = {16'h0, sel_vec()};
      `PVCFG_HDR_DFEAT_HI: r = offer_hi;                      // RULE24
      `PVCFG_HDR_GFEAT_HI: r = accept_hi_reg;
      default:             r = 32'h0;                         // RULE25
    endcase
    return r;
  endfunction

  // capability reads; writes have no target
  // the table is built from constants, so a write cannot land
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cap_rdata_reg <= 32'h0;
    end else begin
      cap_rdata_reg <= 32'h0;
      if (CAP_REQ_I.rd) begin
        for (int i = 0; i < NUM_LOC; i++) begin
          if (CAP_REQ_I.addr >= 8'(CAP_BASE + 8'(12 * i)) &&
              CAP_REQ_I.addr <  8'(CAP_BASE + 8'(12 * (i + 1))))
            cap_rdata_reg <= loc_word(loc_entry(i),
                                      4'(CAP_REQ_I.addr - 8'(CAP_BASE + 8'(12 * i)))); // RULE4
        end
      end
    end
  end

  // header and legacy read data
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hdr_rdata_reg <= 32'h0;
      leg_rdata_reg <= 32'h0;
    end else begin
      hdr_rdata_reg <= HDR_REQ_I.rd ? hdr_read(HDR_REQ_I.addr) : 32'h0; // RULE26
      if (!LEG_REQ_I.rd)
        leg_rdata_reg <= 32'h0;
      else if (LEG_REQ_I.addr == `PVCFG_LEG_ISR)
        leg_rdata_reg <= {31'h0, isr_sync_reg};               // RULE11 RULE21
      else if (LEG_REQ_I.addr == `PVCFG_LEG_NOTIFY)
        leg_rdata_reg <= 32'h0;
      else if (LEG_REQ_I.addr < leg_dev_base)
        leg_rdata_reg <= hdr_read(LEG_REQ_I.addr);            // RULE13
      else
        leg_rdata_reg <= 32'h0;
    end
  end

  // notify and ISR side effects from the legacy mirror
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      notify_reg     <= 16'h0;
      notify_stb_reg <= 1'b0;
      isr_rd_reg     <= 1'b0;
    end else begin
      notify_stb_reg <= LEG_REQ_I.wr && LEG_REQ_I.addr == `PVCFG_LEG_NOTIFY; // RULE21
      if (LEG_REQ_I.wr && LEG_REQ_I.addr == `PVCFG_LEG_NOTIFY)
        notify_reg <= LEG_REQ_I.wdata[15:0];
      isr_rd_reg <= LEG_REQ_I.rd && LEG_REQ_I.addr == `PVCFG_LEG_ISR;
    end
  end

  // writable header fields; read-only and reserved writes dropped
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      accept_lo_reg <= 32'h0;
      accept_hi_reg <= 32'h0;
      ring_sel_reg  <= 16'h0;
      status_reg    <= 8'h0;
      cfg_vec_reg   <= `PVCFG_NO_VECTOR;
      dev_reset_reg <= 1'b0;
      for (int i = 0; i < NUM_RINGS; i++) begin
        ring_page_reg[i] <= 32'h0;
        ring_vec_reg[i]  <= `PVCFG_NO_VECTOR;
      end
    end else begin
      dev_reset_reg <= 1'b0;
      if (hdr_rq.wr) begin
        case (hdr_rq.addr)                                    // RULE16 RULE26
          `PVCFG_HDR_GFEAT_LO: accept_lo_reg <= merge(accept_lo_reg, hdr_rq.wdata, hdr_rq.be);
          `PVCFG_HDR_QADDR:
            if (sel_valid)
              ring_page_reg[sel_idx[0 +: $clog2(NUM_RINGS)]] <= hdr_rq.wdata;
          `PVCFG_HDR_QSEL:     ring_sel_reg <= hdr_rq.wdata[15:0];
          `PVCFG_HDR_STATUS:
            // zero returns every header field to its reset value
            if (hdr_rq.wdata[7:0] == 8'h00) begin             // RULE22
              dev_reset_reg <= 1'b1;
              accept_lo_reg <= 32'h0;
              accept_hi_reg <= 32'h0;
              ring_sel_reg  <= 16'h0;
              status_reg    <= 8'h0;
              cfg_vec_reg   <= `PVCFG_NO_VECTOR;
              for (int i = 0; i < NUM_RINGS; i++) begin
                ring_page_reg[i] <= 32'h0;
                ring_vec_reg[i]  <= `PVCFG_NO_VECTOR;
              end
            end else begin
              status_reg <= hdr_rq.wdata[7:0] & (`PVCFG_ST_FOUND | `PVCFG_ST_DRIVER |
                            `PVCFG_ST_READY | `PVCFG_ST_GAVE_UP); // RULE23
            end
          `PVCFG_HDR_CFGVEC:   cfg_vec_reg <= hdr_rq.wdata[15:0];
          `PVCFG_HDR_QVEC:
            if (sel_valid)
              ring_vec_reg[sel_idx[0 +: $clog2(NUM_RINGS)]] <= hdr_rq.wdata[15:0];
          `PVCFG_HDR_GFEAT_HI: accept_hi_reg <= merge(accept_hi_reg, hdr_rq.wdata, hdr_rq.be);
          default: ;                                          // RULE25
        endcase
      end
    end
  end

  // registered copies of the selected ring page and the gated features
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ring_page_out_reg <= 32'h0;
      feat_out_reg      <= 64'h0;
    end else begin
      ring_page_out_reg <= sel_page();
      // high accepted features hidden unless the gate bit is accepted
      feat_out_reg      <= {accept_lo_reg[`PVCFG_FEAT_HI_GATE] ? accept_hi_reg : 32'h0,
                            accept_lo_reg};                   // RULE24
    end
  end

  assign CAP_RDATA_O   = cap_rdata_reg;
  assign HDR_RDATA_O   = hdr_rdata_reg;
  assign LEG_RDATA_O   = leg_rdata_reg;
  assign NOTIFY_O      = notify_reg;
  assign NOTIFY_STB_O  = notify_stb_reg;
  assign ISR_READ_O    = isr_rd_reg;
  assign STATUS_O      = status_reg;
  assign DEV_RESET_O   = dev_reset_reg;
  assign RING_SEL_O    = ring_sel_reg;
  assign RING_PAGE_O   = ring_page_out_reg;
  assign FEAT_ACCEPT_O = feat_out_reg;                        // RULE24

endmodule
`default_nettype wire

/* tb/pvcfg_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pvcfg_regs_chk
  import pvcfg_pkg::*;
#(
  parameter logic [7:0] CAP_BASE = 8'h40
) (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire pvcfg_req_t  CAP_REQ_I,
  input wire pvcfg_req_t  HDR_REQ_I,
  input wire pvcfg_req_t  LEG_REQ_I,
  input wire logic [31:0] CAP_RDATA_O,
  input wire logic [15:0] NOTIFY_O,
  input wire logic        NOTIFY_STB_O,
  input wire logic        ISR_READ_O,
  input wire logic [7:0]  STATUS_O,
  input wire logic [63:0] FEAT_ACCEPT_O,
  input wire logic        DEV_RESET_O,
  input wire logic [15:0] RING_SEL_O
);
  logic [31:0] hdr_wd_reg;
  logic [31:0] leg_wd_reg;
  logic        isr_reg;
  logic [7:0]  sid_reg;
  logic [7:0]  nxt_reg;
  logic [7:0]  rel;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  assign rel = CAP_REQ_I.addr - CAP_BASE;

  // last request data and expected locator bytes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hdr_wd_reg <= 32'h0;
      leg_wd_reg <= 32'h0;
      isr_reg    <= 1'b0;
      sid_reg    <= 8'h0;
      nxt_reg    <= 8'h0;
    end else begin
      hdr_wd_reg <= HDR_REQ_I.wdata;
      leg_wd_reg <= LEG_REQ_I.wdata;
      isr_reg    <= LEG_REQ_I.rd && LEG_REQ_I.addr == 8'h13;
      sid_reg    <= rel / 8'h0C + 8'h01;
      nxt_reg    <= (rel == 8'h24) ? 8'h00 : CAP_REQ_I.addr + 8'h0C;
    end
  end

  sequence s_word0_rd;
    CAP_REQ_I.rd && (rel == 8'h00 || rel == 8'h0C || rel == 8'h18 || rel == 8'h24);
  endsequence
  sequence s_st_wr;
    HDR_REQ_I.wr && HDR_REQ_I.addr == 8'h12;
  endsequence
  sequence s_ntf_wr;
    LEG_REQ_I.wr && LEG_REQ_I.addr == 8'h10;
  endsequence

  chk_cap_id_len: assert property (s_word0_rd |=> CAP_RDATA_O[7:0] == 8'h09 && CAP_RDATA_O[23:16] == 8'h0C)
    else $error("locator id or length wrong");
  chk_sid_order: assert property (s_word0_rd |=> CAP_RDATA_O[31:24] == sid_reg)
    else $error("structure id wrong");
  chk_chain_next: assert property (s_word0_rd |=> CAP_RDATA_O[15:8] == nxt_reg)
    else $error("next pointer wrong");
  chk_rdata_idle: assert property (!CAP_REQ_I.rd |=> CAP_RDATA_O == 32'h0)
    else $error("config read data not idle");
  chk_status_mask: assert property (s_st_wr |=> STATUS_O == (hdr_wd_reg[7:0] & 8'h87))
    else $error("status value wrong");
  chk_zero_resets: assert property (s_st_wr ##0 HDR_REQ_I.wdata[7:0] == 8'h00 |=> DEV_RESET_O ##1 !DEV_RESET_O)
    else $error("device reset pulse wrong");
  chk_feat_gate: assert property (!FEAT_ACCEPT_O[31] |-> FEAT_ACCEPT_O[63:32] == 32'h0)
    else $error("high features not gated");
  chk_notify_pulse: assert property (s_ntf_wr |=> NOTIFY_STB_O && NOTIFY_O == leg_wd_reg[15:0] ##1 !NOTIFY_STB_O)
    else $error("notify strobe wrong");
  chk_isr_strobe: assert property (ISR_READ_O == isr_reg)
    else $error("isr read strobe wrong");
  chk_select_write: assert property (HDR_REQ_I.wr && HDR_REQ_I.addr == 8'h0E |=> RING_SEL_O == hdr_wd_reg[15:0])
    else $error("ring select wrong");
endmodule

bind pvcfg_regs pvcfg_regs_chk #(.CAP_BASE(CAP_BASE)) i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CAP_REQ_I(CAP_REQ_I), .HDR_REQ_I(HDR_REQ_I), .LEG_REQ_I(LEG_REQ_I), .CAP_RDATA_O(CAP_RDATA_O),
  .NOTIFY_O(NOTIFY_O), .NOTIFY_STB_O(NOTIFY_STB_O), .ISR_READ_O(ISR_READ_O), .STATUS_O(STATUS_O),
  .FEAT_ACCEPT_O(FEAT_ACCEPT_O), .DEV_RESET_O(DEV_RESET_O), .RING_SEL_O(RING_SEL_O));
`default_nettype wire

/* tb/pvcfg_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pvcfg_host_model
  import pvcfg_pkg::*;
(
  input  wire logic        clk_i,        // bus clock
  output var pvcfg_req_t   cap_req_o,    // config access
  output var pvcfg_req_t   hdr_req_o,    // header access
  output var pvcfg_req_t   leg_req_o,    // legacy access
  input  wire logic [31:0] cap_rdata_i,  // config read data
  input  wire logic [31:0] hdr_rdata_i,  // header read data
  input  wire logic [31:0] leg_rdata_i   // legacy read data
);
  logic [31:0] loc_ofs [1:4];
  logic [31:0] loc_map [1:4];
  logic [4:1]  use_leg;
  int          loc_cnt;

  // requests idle from time zero
  initial begin
    cap_req_o = '0;
    hdr_req_o = '0;
    leg_req_o = '0;
  end

  // one-cycle request, answer one cycle later
  task automatic access(input pvcfg_space_t sp, input logic wr, input logic [7:0] addr,
                        input logic [3:0] be, input logic [31:0] wdata, output logic [31:0] rdata);
    pvcfg_req_t r;
    r = '{rd: !wr, wr: wr, addr: addr, be: be, wdata: wdata};
    @(posedge clk_i);
    if (sp == PVCFG_SPACE_CAP) cap_req_o <= r;
    else if (sp == PVCFG_SPACE_HEADER) hdr_req_o <= r;
    else leg_req_o <= r;
    @(posedge clk_i);
    cap_req_o <= '0;
    hdr_req_o <= '0;
    leg_req_o <= '0;
    #1;
    rdata = (sp == PVCFG_SPACE_CAP) ? cap_rdata_i : (sp == PVCFG_SPACE_HEADER) ? hdr_rdata_i : leg_rdata_i;
  endtask

  // walk the capability list, keep known locators
  task automatic scan(input logic [7:0] base);
    logic [31:0] w;
    logic [7:0]  p;
    logic [7:0]  sid;
    logic [31:0] v;
    loc_cnt = 0;
    use_leg = 4'hF;
    p = base;
    for (int n = 0; n < 8 && p != 8'h00; n++) begin
      access(PVCFG_SPACE_CAP, 1'b0, p, 4'hF, 32'h0, w);
      sid = w[31:24];
      if (w[7:0] == 8'h09 && w[23:16] == 8'h0C && sid inside {[8'h01:8'h04]}) begin
        access(PVCFG_SPACE_CAP, 1'b0, p + 8'h04, 4'hF, 32'h0, v);
        if (v[2:0] <= 3'h5) begin
          loc_map[sid] = ({v[31:3], 3'h0} > 32'h1000) ? 32'h1000 : {v[31:3], 3'h0};
          access(PVCFG_SPACE_CAP, 1'b0, p + 8'h08, 4'hF, 32'h0, loc_ofs[sid]);
          // drop offset bits below each structure's alignment
          loc_ofs[sid][1:0] = loc_ofs[sid][1:0] & ((sid == 8'h01) ? 2'b00 :
                              (sid == 8'h02) ? 2'b10 : 2'b11);
          use_leg[sid] = 1'b0;
          loc_cnt++;
        end
      end
      p = w[15:8];
    end
  endtask
endmodule
`default_nettype wire

/* tb/pci_vendor_cap_config_header_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pci_vendor_cap_config_header_tb;
  import pvcfg_pkg::*;
  localparam logic [31:0] LOC_SIZE [1:4] = '{32'h100, 32'h2, 32'h1, 32'h20};
  localparam logic [31:0] LOC_OFS  [1:4] = '{32'h1000, 32'h1200, 32'h1300, 32'h1400};
  logic        clk = 1'b0;
  logic        rst_n;
  logic        msix_en;
  logic        isr_status;
  pvcfg_req_t  cap_req, hdr_req, leg_req;
  logic [31:0] cap_rdata, hdr_rdata, leg_rdata, ring_page, q;
  logic [15:0] notify, ring_sel;
  logic        notify_stb, isr_read, dev_reset;
  logic [7:0]  status;
  logic [63:0] feat;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  pvcfg_host_model i_host (.clk_i(clk), .cap_req_o(cap_req), .hdr_req_o(hdr_req),
    .leg_req_o(leg_req), .cap_rdata_i(cap_rdata), .hdr_rdata_i(hdr_rdata), .leg_rdata_i(leg_rdata));

  pvcfg_regs i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CAP_REQ_I(cap_req), .HDR_REQ_I(hdr_req),
    .LEG_REQ_I(leg_req), .MSIX_EN_I(msix_en), .ISR_STATUS_I(isr_status), .CAP_RDATA_O(cap_rdata),
    .HDR_RDATA_O(hdr_rdata), .LEG_RDATA_O(leg_rdata), .NOTIFY_O(notify), .NOTIFY_STB_O(notify_stb),
    .ISR_READ_O(isr_read), .STATUS_O(status), .FEAT_ACCEPT_O(feat), .DEV_RESET_O(dev_reset),
    .RING_PAGE_O(ring_page), .RING_SEL_O(ring_sel));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input pvcfg_space_t sp, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    i_host.access(sp, 1'b1, a, be, d, q);
  endtask

  task automatic rdc(input pvcfg_space_t sp, input logic [7:0] a, input logic [31:0] exp);
    i_host.access(sp, 1'b0, a, 4'hF, 32'h0, q);
    check(64'(q), 64'(exp));
  endtask

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    msix_en = 1'b0;
    isr_status = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    i_host.scan(8'h40);
    check(64'(i_host.loc_cnt), 64'h4);
    check(64'(i_host.loc_map[1]), 64'h100);
    check(64'(i_host.use_leg), 64'h0);
    for (int k = 1; k <= 4; k++) begin
      check(64'(i_host.loc_ofs[k]), 64'(LOC_OFS[k]));
      rdc(PVCFG_SPACE_CAP, 8'(8'h44 + 12 * (k - 1)), {LOC_SIZE[k][31:3], 3'h1});
    end
    wr(PVCFG_SPACE_CAP, 8'h40, 4'hF, 32'h0);
    rdc(PVCFG_SPACE_CAP, 8'h40, 32'h010C_4C09);
    rdc(PVCFG_SPACE_HEADER, 8'h0C, 32'h0000_0100);
    rdc(PVCFG_SPACE_HEADER, 8'h14, 32'hFFFF_FFFF);
    wr(PVCFG_SPACE_HEADER, 8'h00, 4'hF, 32'h0);
    rdc(PVCFG_SPACE_HEADER, 8'h00, 32'h8000_0000);
    wr(PVCFG_SPACE_HEADER, 8'h10, 4'h3, 32'hFFFF);
    rdc(PVCFG_SPACE_HEADER, 8'h10, 32'h0);
    // ring select, page and size
    wr(PVCFG_SPACE_HEADER, 8'h0E, 4'h3, 32'h1);
    wr(PVCFG_SPACE_HEADER, 8'h08, 4'hF, 32'h0001_2345);
    @(posedge clk);
    #1;
    check(64'(ring_page), 64'h12345);
    rdc(PVCFG_SPACE_HEADER, 8'h0C, 32'h0001_0100);
    wr(PVCFG_SPACE_HEADER, 8'h0E, 4'h3, 32'h0);
    @(posedge clk);
    #1;
    check(64'(ring_page), 64'h0);
    wr(PVCFG_SPACE_HEADER, 8'h0E, 4'h3, 32'h2);
    rdc(PVCFG_SPACE_HEADER, 8'h0C, 32'h0002_0000);
    // feature gating on accepted bit 31
    wr(PVCFG_SPACE_HEADER, 8'h1C, 4'hF, 32'hFFFF_FFFF);
    wr(PVCFG_SPACE_HEADER, 8'h04, 4'hF, 32'h7FFF_FFFF);
    @(posedge clk);
    #1;
    check(feat, 64'h0000_0000_7FFF_FFFF);
    wr(PVCFG_SPACE_HEADER, 8'h04, 4'hF, 32'h8000_0001);
    @(posedge clk);
    #1;
    check(feat, 64'hFFFF_FFFF_8000_0001);
    // every status bit, then zero
    for (int k = 0; k < 8; k++) begin
      wr(PVCFG_SPACE_HEADER, 8'h12, 4'h1, 32'(8'h01 << k));
      check(64'(status), 64'((8'h01 << k) & 8'h87));
    end
    wr(PVCFG_SPACE_HEADER, 8'h12, 4'h1, 32'h0);
    check(64'({dev_reset, status}), 64'h100);
    // vectors and legacy mirror
    wr(PVCFG_SPACE_HEADER, 8'h14, 4'h3, 32'h3);
    wr(PVCFG_SPACE_HEADER, 8'h16, 4'h3, 32'h7);
    rdc(PVCFG_SPACE_HEADER, 8'h14, 32'h0007_0003);
    rdc(PVCFG_SPACE_LEGACY, 8'h00, 32'h8000_0001 & 32'hFFFF_FFFF ^ 32'h1);
    wr(PVCFG_SPACE_LEGACY, 8'h10, 4'h3, 32'h1);
    check(64'({notify_stb, notify}), 64'h1_0001);
    @(posedge clk);
    isr_status <= 1'b1;
    repeat (2) @(posedge clk);
    i_host.access(PVCFG_SPACE_LEGACY, 1'b0, 8'h13, 4'h1, 32'h0, q);
    check(64'(isr_read), 64'h1);
    check(64'(q), 64'h1);
    @(posedge clk);
    msix_en <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(PVCFG_SPACE_LEGACY, 8'h14, 32'h0007_0003);
    rdc(PVCFG_SPACE_CAP, 8'h48, 32'h0000_1000);
    // reset in mid-run, with select and status away from zero
    wr(PVCFG_SPACE_HEADER, 8'h0E, 4'h3, 32'h1);
    wr(PVCFG_SPACE_HEADER, 8'h12, 4'h1, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    check(64'({ring_sel, status}), 64'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    rdc(PVCFG_SPACE_HEADER, 8'h14, 32'hFFFF_FFFF);
    results();
  end
endmodule
`default_nettype wire
